// [hdl/cism_pkg.sv]
// constants, register map and address decode for the codec interrupt block
// assumes a 100 MHz ref_clk and an AXI4-Lite master with 32-bit data
package cism_pkg;

  localparam int NSRC   = 10;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [9:0] FLAGS_IDX = 10'h07f;
  localparam logic [9:0] MASKS_IDX = 10'h080;
  localparam logic [9:0] POL_IDX   = 10'h081;
  localparam logic [9:0] DB_IDX    = 10'h082;

  ////////////////////////////////////////////////////////////////////////////
  // bit positions, shared by flags, masks, polarity and debounce
  localparam int SUMMARY_BIT    = 10;
  localparam int BIT_BITCLK_PIN = 9;
  localparam int BIT_SEQUENCER  = 8;
  localparam int BIT_PIN_THREE  = 7;
  localparam int BIT_PIN_TWO    = 6;
  localparam int BIT_PIN_ONE    = 5;
  localparam int BIT_IN_EIGHT   = 4;
  localparam int BIT_IN_SEVEN   = 3;
  localparam int BIT_LOOP_LOCK  = 2;
  localparam int BIT_BIAS_SHORT = 1;
  localparam int BIT_BIAS_DET   = 0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [NSRC-1:0] FLAGS_RST = 10'h000;
  localparam logic [NSRC-1:0] MASKS_RST = 10'h3ff;
  localparam logic [NSRC-1:0] POL_RST   = 10'h000;
  localparam logic [NSRC-1:0] DB_RST    = 10'h000;

  ////////////////////////////////////////////////////////////////////////////
  // debounce timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DB_TICK_NS    = 1000;
  localparam int DB_TICK_CYC   = (DB_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DB_TICKS      = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {
    SEL_NONE,
    SEL_FLAGS,
    SEL_MASKS,
    SEL_POL,
    SEL_DB
  } cism_sel_e;

  function automatic cism_sel_e cism_decode(input logic [ADDR_W-1:0] addr);
    cism_sel_e sel;
    sel = SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr[ADDR_W-1:2])
        FLAGS_IDX: sel = SEL_FLAGS;
        MASKS_IDX: sel = SEL_MASKS;
        POL_IDX:   sel = SEL_POL;
        DB_IDX:    sel = SEL_DB;
        default:   sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction

endpackage

// [hdl/cism_debounce.sv]
// one-source debouncer, driven by a shared slow tick enable
// assumes raw is already synchronised to ref_clk
`timescale 1ns/10ps
module cism_debounce (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic tick,
  input  wire logic enable,
  input  wire logic raw,
  output logic      clean_q
);

  logic [2:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // disabled: pass through with one flop of delay
  // enabled: raw must differ from clean for DB_TICKS ticks in a row
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      clean_q <= 1'b0;
      cnt_q   <= 3'h0;
    end else if (!enable) begin
      clean_q <= raw;
      cnt_q   <= 3'h0;
    end else if (raw == clean_q) begin
      cnt_q <= 3'h0;
    end else if (tick) begin
      if (cnt_q == 3'(cism_pkg::DB_TICKS - 1)) begin
        clean_q <= raw;
        cnt_q   <= 3'h0;
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

endmodule

// [hdl/cism_top.sv]
// codec interrupt flags, masks, polarity and debounce behind an AXI4-Lite slave
// assumes src_in are asynchronous levels; one write and one read at a time
//
// Summary of operation
// R1: status bit 10 reads as OR of all ten event flags, read-only.
// R2: flag sets on its event, stays until a 1 is written there.
// R3: flag bits: bitclk pin 9, sequencer 8, pins 7..5, inputs 4..3, lock 2, 1, 0.
// R4: all flags and the summary bit reset to zero.
// R5: software ignores the sequencer flag read while the sequencer is busy.
// R6: one mask bit per source at its flag position; 1 masks it.
// R7: all ten mask bits reset to one, every source masked.
// R8: loop lock mask at bit 2, bias current detect mask at bit 0.
// R9: per-source polarity, default 0 active high, 1 triggers on opposite level.
// R10: per-source debounce enable, default off, debounces source before flag.
// R11: masked source still flags but does not drive the interrupt output.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
module cism_top (
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  input  wire logic [cism_pkg::NSRC-1:0]    src_in,
  input  wire logic [cism_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [cism_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [cism_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [cism_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic                              irq
);

  localparam int N = cism_pkg::NSRC;

  logic [N-1:0]                  sync1_q;
  logic [N-1:0]                  sync2_q;
  logic [N-1:0]                  sync3_q;
  logic [N-1:0]                  sync_q;
  logic [N-1:0]                  clean_w;
  logic [N-1:0]                  set_w;
  logic [N-1:0]                  clr_w;
  logic [N-1:0]                  flags_q;
  logic [N-1:0]                  mask_q;
  logic [N-1:0]                  pol_q;
  logic [N-1:0]                  db_q;
  logic                          irq_q;
  logic [6:0]                    tick_cnt_q;
  logic                          tick_q;
  logic                          awready_q;
  logic                          wready_q;
  logic                          aw_got_q;
  logic                          w_got_q;
  logic [cism_pkg::ADDR_W-1:0]   waddr_q;
  logic [cism_pkg::DATA_W-1:0]   wdata_q;
  logic [3:0]                    wstrb_q;
  logic                          bvalid_q;
  logic [1:0]                    bresp_q;
  logic                          arready_q;
  logic                          rvalid_q;
  logic [1:0]                    rresp_q;
  logic [cism_pkg::DATA_W-1:0]   rdata_q;
  logic                          do_write_w;
  cism_pkg::cism_sel_e           wsel_w;
  cism_pkg::cism_sel_e           rsel_w;
  logic [N-1:0]                  wbits_w;
  logic [N-1:0]                  wen_w;

  ////////////////////////////////////////////////////////////////////////////
  // three-flop synchroniser; a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      sync_q  <= '0;
    end else begin
      sync1_q <= src_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      sync_q  <= (sync2_q & sync3_q) | (sync_q & (sync2_q ^ sync3_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slow tick shared by all debouncers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tick_cnt_q <= 7'h00;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 7'(cism_pkg::DB_TICK_CYC - 1)) begin
      tick_cnt_q <= 7'h00;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 7'h01;
      tick_q     <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N; gi = gi + 1) begin : g_src
      cism_debounce u_db (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .tick    (tick_q),
        .enable  (db_q[gi]),
        .raw     (sync_q[gi]),
        .clean_q (clean_w[gi])
      ); // [R10]
    end
  endgenerate

  // level-sensitive: a condition still active re-sets the flag after a clear
  assign set_w = clean_w ^ pol_q; // [R9]

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel; address and data accepted in either order
  assign wsel_w     = cism_pkg::cism_decode(waddr_q);
  assign do_write_w = aw_got_q && w_got_q && !bvalid_q;
  assign wen_w      = {{2{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wbits_w    = wdata_q[N-1:0] & wen_w;
  assign clr_w      = (do_write_w && wsel_w == cism_pkg::SEL_FLAGS) ? wbits_w : '0;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      awready_q <= 1'b0;
      aw_got_q  <= 1'b0;
      waddr_q   <= '0;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_got_q  <= 1'b1;
      waddr_q   <= s_axi_awaddr;
    end else if (do_write_w) begin
      aw_got_q <= 1'b0;
    end else if (!aw_got_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wready_q <= 1'b0;
      w_got_q  <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_got_q  <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_write_w) begin
      w_got_q <= 1'b0;
    end else if (!w_got_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= cism_pkg::RESP_OKAY;
    end else if (do_write_w) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wsel_w == cism_pkg::SEL_NONE) ? cism_pkg::RESP_SLVERR
                                                 : cism_pkg::RESP_OKAY;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers, byte lanes honoured
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mask_q <= cism_pkg::MASKS_RST; // [R7]
    end else if (do_write_w && wsel_w == cism_pkg::SEL_MASKS) begin
      mask_q <= (mask_q & ~wen_w) | wbits_w; // [R6] [R8]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pol_q <= cism_pkg::POL_RST; // [R9]
    end else if (do_write_w && wsel_w == cism_pkg::SEL_POL) begin
      pol_q <= (pol_q & ~wen_w) | wbits_w;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      db_q <= cism_pkg::DB_RST; // [R10]
    end else if (do_write_w && wsel_w == cism_pkg::SEL_DB) begin
      db_q <= (db_q & ~wen_w) | wbits_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      flags_q <= cism_pkg::FLAGS_RST; // [R4]
    end else begin
      flags_q <= (flags_q & ~clr_w) | set_w; // [R2] [R3]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_q & ~mask_q); // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  assign rsel_w = cism_pkg::cism_decode(s_axi_araddr);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= cism_pkg::RESP_OKAY;
      rdata_q   <= '0;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= cism_pkg::RESP_OKAY;
      case (rsel_w)
        cism_pkg::SEL_FLAGS: rdata_q <= {21'h0, |flags_q, flags_q}; // [R1]
        cism_pkg::SEL_MASKS: rdata_q <= {22'h0, mask_q};
        cism_pkg::SEL_POL:   rdata_q <= {22'h0, pol_q};
        cism_pkg::SEL_DB:    rdata_q <= {22'h0, db_q};
        default: begin
          rdata_q <= '0;
          rresp_q <= cism_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign irq           = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  logic [N-1:0] hold_w;
  assign hold_w = flags_q & ~clr_w;

  AST_SUMMARY_OR: assert property ( // [R1]
    $rose(rvalid_q) && rresp_q == cism_pkg::RESP_OKAY
      && $past(rsel_w) == cism_pkg::SEL_FLAGS
      |-> rdata_q[cism_pkg::SUMMARY_BIT] == |rdata_q[N-1:0])
    else $error("summary bit differs from OR of flags");

  AST_FLAG_STICKY: assert property ( // [R2]
    1'b1 |=> (flags_q & $past(hold_w)) == $past(hold_w))
    else $error("flag dropped without a write of one");

  AST_FLAG_CLEAR: assert property ( // [R2]
    |(clr_w & ~set_w) |=> (flags_q & $past(clr_w & ~set_w)) == '0)
    else $error("flag not cleared by write of one");

  AST_SEQ_POSITION: assert property ( // [R3]
    set_w[cism_pkg::BIT_SEQUENCER] |=> flags_q[cism_pkg::BIT_SEQUENCER])
    else $error("sequencer event missed at bit 8");

  AST_RESET_STATE: assert property (disable iff (1'b0) // [R4]
    !resetn |=> flags_q == cism_pkg::FLAGS_RST && mask_q == cism_pkg::MASKS_RST
      && !irq_q)
    else $error("reset values wrong");

  AST_MASK_WRITE: assert property ( // [R6]
    do_write_w && wsel_w == cism_pkg::SEL_MASKS && wstrb_q[1:0] == 2'h3
      |=> mask_q == $past(wdata_q[N-1:0]) && bvalid_q ##1 $stable(mask_q))
    else $error("mask register did not take the write");

  AST_LOCK_POLARITY: assert property ( // [R9] [R3]
    !db_q[cism_pkg::BIT_LOOP_LOCK] && !pol_q[cism_pkg::BIT_LOOP_LOCK]
      && sync_q[cism_pkg::BIT_LOOP_LOCK] [*2]
      |=> flags_q[cism_pkg::BIT_LOOP_LOCK])
    else $error("active-high lock event not flagged");

  AST_DB_BYPASS: assert property ( // [R10]
    !db_q[0] [*2] |-> clean_w[0] == $past(sync_q[0]))
    else $error("debounce off but source delayed");

  AST_MASKED_QUIET: assert property ( // [R11]
    (flags_q & ~mask_q) == '0 [*2] |-> !irq_q ##1 1'b1)
    else $error("interrupt raised by masked source");

  AST_WRITE_RESP: assert property (
    s_axi_awvalid && awready_q ##0 (s_axi_wvalid && wready_q) |-> ##[1:2] bvalid_q)
    else $error("write response late");

  AST_IRQ_UNMASKED: assert property ( // [R11]
    |(flags_q & ~mask_q) |=> irq_q)
    else $error("unmasked flag did not raise the interrupt");

  AST_LOCK_MASK_BIT: assert property ( // [R8]
    do_write_w && wsel_w == cism_pkg::SEL_MASKS && wstrb_q[0]
      |=> mask_q[cism_pkg::BIT_LOOP_LOCK] == $past(wdata_q[cism_pkg::BIT_LOOP_LOCK]))
    else $error("loop lock mask not at bit 2");

  // the upper lane left out of the strobe must keep mask bits 9:8
  AST_MASK_LANE_KEEP: assert property ( // [R6]
    do_write_w && wsel_w == cism_pkg::SEL_MASKS && !wstrb_q[1]
      |=> mask_q[N-1:8] == $past(mask_q[N-1:8]))
    else $error("mask bits changed outside the write strobe");

  AST_BAD_WRITE_QUIET: assert property ( // [R6]
    do_write_w && wsel_w == cism_pkg::SEL_NONE
      |=> $stable(mask_q) && $stable(pol_q) && $stable(db_q)
        && bresp_q == cism_pkg::RESP_SLVERR)
    else $error("unmapped write touched a register or was not refused");

  AST_READ_ANSWER: assert property (
    s_axi_arvalid && arready_q |=> rvalid_q && !arready_q)
    else $error("read answer missing after address taken");

  COV_IRQ_RISE:    cover property ($rose(irq_q));
  COV_CLEAR_WRITE: cover property (|clr_w ##1 !irq_q);
  COV_MASKED_SET:  cover property (|(set_w & mask_q) && !irq_q);
  COV_DB_SET:      cover property (db_q[cism_pkg::BIT_IN_EIGHT] && set_w[cism_pkg::BIT_IN_EIGHT]);

endmodule

// [test/cism_src_model.sv]
// event source model: drives the ten source levels seen by the block
// assumes the bench calls its tasks from the ref_clk domain
`timescale 1ns/10ps
module cism_src_model (
  input  wire logic       ref_clk,
  output logic      [9:0] src_out
);
  initial src_out = 10'h000;

  ////////////////////////////////////////////////////////////////////////////
  // plain logic drivers, no pulls: a level holds until changed
  task automatic set_lvl(input int i, input logic v);
    @(posedge ref_clk);
    src_out[i] <= v;
  endtask

  task automatic pulse(input int i, input int n);
    set_lvl(i, 1'b1);
    repeat (n) @(posedge ref_clk);
    src_out[i] <= 1'b0;
  endtask
endmodule

// [test/codec_interrupt_status_mask_test.sv]
// self-checking bench for the codec interrupt block over AXI4-Lite
// assumes cism_pkg, cism_top and cism_src_model are compiled before it
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module codec_interrupt_status_mask_test;
  localparam logic [11:0] A_FLG = {cism_pkg::FLAGS_IDX, 2'h0};
  localparam logic [11:0] A_MSK = {cism_pkg::MASKS_IDX, 2'h0};
  localparam logic [11:0] A_POL = {cism_pkg::POL_IDX, 2'h0};
  localparam logic [11:0] A_DB  = {cism_pkg::DB_IDX, 2'h0};
  localparam logic [11:0] A_BAD = 12'h1f8;
  localparam logic [1:0]  OK    = cism_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR   = cism_pkg::RESP_SLVERR;
  logic        ref_clk, resetn, irq;
  logic [9:0]  src_in;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          fails = 0;
  int          checked = 0;

  cism_top u_cism_top (
    .ref_clk(ref_clk), .resetn(resetn), .src_in(src_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq)
  );

  cism_src_model u_cism_src_model (
    .ref_clk(ref_clk),
    .src_out(src_in)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic hang(input int n);
    if (n >= 200) begin
      fails++;
      $display("MISMATCH handshake expected answer seen timeout");
      final_report();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic tdone(input string nm);
    $display("test %s done", nm);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic aw_d;
    logic w_d;
    n = 0;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_d && w_d) && n < 200) begin
      @(posedge ref_clk);
      n++;
      if (!aw_d && s_axi_awready) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_d && s_axi_wready) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge ref_clk);
      n++;
    end while (!s_axi_bvalid && n < 200);
    s_axi_bready <= 1'b0;
    hang(n);
    `CHK("bresp", er, s_axi_bresp)
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    s_axi_rready <= 1'b0;
    hang(n);
    `CHK(nm, ed, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask

  // summary bit expected as the or of the ten flags
  task automatic rdf(input logic [9:0] f);
    rd("flags", A_FLG, {21'h0, |f, f}, OK);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    cyc(5);
    resetn <= 1'b1;
    rdf(10'h000);
    rd("masks", A_MSK, 32'h3ff, OK);
    rd("polarity", A_POL, 32'h0, OK);
    rd("debounce", A_DB, 32'h0, OK);
    `CHK("irq", 1'b0, irq)
    tdone("reset");
    for (int i = 0; i < 10; i++) begin
      u_cism_src_model.pulse(i, 8);
      cyc(12); // sequencer busy has ended before the read
      rdf(10'h001 << i);
      `CHK("irq", 1'b0, irq)
      wr(A_FLG, 32'h400, OK);
      rdf(10'h001 << i);
      wr(A_FLG, 32'h001 << i, OK);
      rdf(10'h000);
    end
    tdone("events");
    wr(A_MSK, 32'hffffffff, OK);
    rd("masks", A_MSK, 32'h3ff, OK);
    wr(A_MSK, 32'h3fb, OK);
    rd("masks", A_MSK, 32'h3fb, OK);
    u_cism_src_model.pulse(0, 8);
    cyc(12);
    `CHK("irq", 1'b0, irq)
    rdf(10'h001);
    u_cism_src_model.pulse(2, 8);
    cyc(12);
    `CHK("irq", 1'b1, irq)
    wr(A_FLG, 32'h004, OK);
    cyc(3);
    `CHK("irq", 1'b0, irq)
    wr(A_MSK, 32'h3fa, OK);
    cyc(3);
    `CHK("irq", 1'b1, irq)
    wr(A_FLG, 32'h001, OK);
    cyc(3);
    `CHK("irq", 1'b0, irq)
    tdone("masks");
    wr(A_POL, 32'h008, OK);
    rd("polarity", A_POL, 32'h008, OK);
    cyc(12);
    rdf(10'h008);
    u_cism_src_model.set_lvl(3, 1'b1);
    cyc(12);
    wr(A_FLG, 32'h008, OK);
    rdf(10'h000);
    wr(A_POL, 32'h000, OK);
    u_cism_src_model.set_lvl(3, 1'b0);
    cyc(12);
    wr(A_FLG, 32'h3ff, OK);
    rdf(10'h000);
    tdone("polarity");
    // short glitch must be filtered, a long level must get through
    wr(A_DB, 32'h010, OK);
    u_cism_src_model.pulse(4, 20);
    cyc(12);
    rdf(10'h000);
    u_cism_src_model.pulse(4, 700);
    cyc(12);
    rdf(10'h010);
    cyc(700);
    wr(A_FLG, 32'h010, OK);
    rdf(10'h000);
    wr(A_DB, 32'h000, OK);
    tdone("debounce");
    rd("unmapped", A_BAD, 32'h0, ERR);
    wr(A_BAD, 32'hffffffff, ERR);
    rd("masks", A_MSK, 32'h3fa, OK);
    tdone("unmapped");
    // low lane only: bits 9:8 must keep their ones
    s_axi_wstrb <= 4'h1;
    wr(A_MSK, 32'h0, OK);
    s_axi_wstrb <= 4'hf;
    rd("masks", A_MSK, 32'h300, OK);
    tdone("strobes");
    final_report();
  end

  initial begin
    cyc(50000);
    fails++;
    $display("MISMATCH run expected end seen timeout");
    final_report();
  end
endmodule
